// file: test/clfc_checker.sv
// Port checker of the cyclic link fault classifier
module clfc_checker
  import clfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic rx_done,
  input wire logic rx_crc_bad,
  input wire logic rx_short,
  input wire logic rx_long,
  input wire logic rx_len_bad,
  input wire logic rx_type_bad,
  input wire logic rx_addr_bad,
  input wire logic rx_supply_fail,
  input wire logic rx_err_bit,
  input wire logic rx_life_missing,
  input wire logic rx_early,
  input wire logic rx_hdr_bad,
  input wire logic rx_buf_bad,
  input wire logic ev_miss,
  input wire logic tx_req,
  input wire logic tx_type_bad,
  input wire logic tx_go,
  input wire logic fault_pulse,
  input wire logic [31:0] fault_msg
);
  logic en_reg; // Mirror of the enable bit
  wire logic nx = en_reg && !reg_wr; // Faults are taken, no register write pending
  wire logic pl = nx && rx_done && !rx_hdr_bad && !rx_buf_bad && !rx_life_missing;
  wire logic oth = rx_crc_bad | rx_short | rx_long | rx_len_bad | rx_type_bad | rx_addr_bad;
  // Follow writes to the control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_reg <= 1'b1;
    end else if (reg_wr && reg_addr == 8'h00) begin
      en_reg <= reg_wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_upper_zero: assert property (fault_pulse |-> fault_msg[31:16] == 16'h0000)
    else $error("upper half set");
  chk_hdr_cause: assert property (nx && rx_done && rx_hdr_bad |=> fault_pulse && fault_msg[7:0] == 8'h20)
    else $error("header cause");
  chk_crc_cause: assert property (pl && rx_crc_bad && !rx_early |=> fault_pulse && fault_msg[7:0] == 8'h01)
    else $error("checksum cause");
  chk_short_early: assert property (pl && rx_short && !rx_crc_bad && rx_early |=> fault_msg[7:0] == 8'h12)
    else $error("short early cause");
  chk_early_only: assert property (pl && rx_early && !oth && !rx_supply_fail && !rx_err_bit |=> fault_msg[7:0] == 8'h10)
    else $error("early cause");
  chk_life_early: assert property (nx && rx_done && rx_life_missing && rx_early && !rx_hdr_bad && !rx_buf_bad |=> fault_msg[7:0] == 8'h1A)
    else $error("life early cause");
  chk_miss_cause: assert property (nx && ev_miss && !rx_done && !(tx_req && tx_type_bad) |=> fault_pulse && fault_msg[7:0] == 8'h21)
    else $error("missing telegram cause");
  chk_tx_block: assert property (tx_go |-> tx_req && !tx_type_bad && en_reg)
    else $error("send not blocked");
endmodule : clfc_checker

// file: test/clfc_partner.sv
// Model of the attached component: hands over one telegram's check flags
module clfc_partner (
  input wire logic clk,
  input wire logic send,
  input wire logic [11:0] defects,
  output logic rx_done,
  output logic [11:0] flags
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_done = 1'b0;
    flags = 12'h000;
  end
  // All twelve flags travel as commanded with the telegram; every flag, sign-of-life and supply included, inverts between telegrams
  always @(posedge clk) begin
    rx_done <= send;
    flags <= send ? defects : ~flags;
  end
endmodule : clfc_partner

// file: test/test_clfc_top.sv
// Testbench of the cyclic link fault classifier
module test_clfc_top import clfc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, send = 0, tx_req = 0, tx_type_bad = 0, en = 1;
  logic [7:0] reg_addr = 8'h00, comp = 8'h00;
  clfc_word_t reg_wdata = 32'h0;
  logic [11:0] defects = 12'h000;
  logic [9:0] ev = 10'h000;
  logic [7:0] code [10] = '{8'h21, 8'h22, 8'h40, 8'h62, 8'h42, 8'h43, 8'h60, 8'h61, 8'h0B, 8'h00};
  wire logic rx_done, tx_go, fault_pulse;
  wire logic [11:0] fl;
  wire logic [31:0] reg_rdata, fault_msg;
  int num_errors = 0, checked = 0, seed = 34, cyc = 0, nf = 0;
  always #4 clk = ~clk;
  clfc_top u_clfc_top(.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_done,
    .rx_crc_bad(fl[0]), .rx_short(fl[1]), .rx_long(fl[2]), .rx_len_bad(fl[3]), .rx_type_bad(fl[4]),
    .rx_addr_bad(fl[5]), .rx_supply_fail(fl[6]), .rx_err_bit(fl[7]), .rx_life_missing(fl[8]),
    .rx_early(fl[9]), .rx_hdr_bad(fl[10]), .rx_buf_bad(fl[11]), .ev_miss(ev[0]), .ev_rx_timeout(ev[1]),
    .ev_tx_timeout(ev[2]), .ev_trans_fail(ev[3]), .ev_tx_buf_bad1(ev[4]), .ev_tx_buf_bad2(ev[5]),
    .ev_rt_late(ev[6]), .ev_char_slow(ev[7]), .ev_alt_sync(ev[8]), .ev_prop_change(ev[9]),
    .tx_req, .tx_type_bad, .tx_go, .fault_pulse, .fault_msg);
  clfc_partner u_clfc_partner(.clk, .send, .defects, .rx_done, .flags(fl));
  task report_and_stop;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask : rd
  // Expected cause of one telegram, by the priority of the hand-over
  function logic [7:0] cause(input logic [11:0] d);
    cause = 8'h00;
    if (d[10]) cause = 8'h20;
    else if (d[11]) cause = 8'h23;
    else if (d[8]) cause = d[9] ? 8'h1A : 8'h0A;
    else if (d[5:0] != 0) begin
      for (int i = 5; i >= 0; i--) if (d[i]) cause = 8'(i + 1) | {3'b000, d[9], 4'h0};
    end else if (d[6]) cause = 8'h09;
    else if (d[9]) cause = d[7] ? 8'h19 : 8'h10;
  endfunction : cause
  task rx(input logic [11:0] d);
    @(posedge clk);
    send <= 1;
    defects <= d;
    @(posedge clk);
    send <= 0;
    @(posedge clk);
    #1 chk({31'h0, fault_pulse}, {31'h0, cause(d) != 0 && en});
    if (cause(d) != 0 && en) chk(fault_msg, {16'h0, comp, cause(d)});
    if (cause(d) != 0 && en) nf++;
  endtask : rx
  task evt(input int i);
    @(posedge clk);
    ev <= 10'(1 << i);
    @(posedge clk);
    ev <= 0;
    #1 chk(fault_msg, i == 9 ? {24'h0, comp} : {16'h0, comp, code[i]});
    chk({31'h0, fault_pulse}, 32'h1);
    nf++;
  endtask : evt
  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    rd(8'h00, 32'h1);
    rd(8'h14, 32'h0);
    comp = 8'($random(seed));
    wr(8'h04, {24'h0, comp});
    for (int i = 0; i < 12; i++) begin
      rx(12'(1 << i));
      rx(12'(1 << i) | 12'h200);
    end
    repeat (40) rx(12'($random(seed)));
    for (int i = 0; i < 10; i++) evt(i);
    @(posedge clk);
    tx_req <= 1;
    tx_type_bad <= 1;
    #1 chk({31'h0, tx_go}, 32'h0);
    @(posedge clk);
    tx_type_bad <= 0;
    #1 chk(fault_msg, {16'h0, comp, 8'h41});
    chk({31'h0, tx_go}, 32'h1);
    nf++;
    @(posedge clk);
    tx_req <= 0;
    wr(8'h00, 32'h0);
    en = 0;
    rx(12'h001);
    wr(8'h00, 32'h1);
    en = 1;
    rd(8'h08, {16'h0, comp, 8'h41});
    rd(8'h04, {24'h0, comp});
    rd(8'h0C, 32'h3);
    rd(8'h10, 32'(nf));
    wr(8'h00, 32'h3);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h00, 32'h1);
    report_and_stop();
  end
endmodule : test_clfc_top
bind clfc_top clfc_checker u_clfc_checker(.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .rx_done,
  .rx_crc_bad, .rx_short, .rx_long, .rx_len_bad, .rx_type_bad, .rx_addr_bad, .rx_supply_fail,
  .rx_err_bit, .rx_life_missing, .rx_early, .rx_hdr_bad, .rx_buf_bad, .ev_miss, .tx_req,
  .tx_type_bad, .tx_go, .fault_pulse, .fault_msg);

// file: verilog/clfc_pkg.sv
// Types of the cyclic link fault classifier
package clfc_pkg;
  typedef logic [31:0] clfc_word_t;
  typedef logic [7:0] clfc_byte_t;
endpackage : clfc_pkg

// file: verilog/clfc_regs.svh
// Constants of the cyclic link fault classifier: register map, fields and cause codes
// Function
// - Message: zero upper half, component, cause
// - Checksum fail gives cause 1
// - Short telegram gives cause 2
// - Long telegram gives cause 3
// - Length disagreeing with receive list: 4
// - Type disagreeing with receive list: 5
// - Power unit address mismatch: 6
// - Remote supply failure indication: 9
// - Early arrival alone gives cause 16
// - Early plus defect 1 to 6 gives combined code
// - Missing sign-of-life bit gives 10
// - Missing sign-of-life and early: 26
// - Missing cyclic telegram gives 33
// - List timeouts: receive 34, send 64
// - Failed transition to cyclic: 98
// - Send type mismatch: block, cause 65
// - Malformed header gives cause 32
// - Buffer corrupt: receive 35, send 66/67
// - Late runtime measurement response: 96
// - Characteristic data exchange too long: 97
// - Alternating cyclic sync loss: 11
// - Property change reports component number only
`ifndef CLFC_REGS_SVH
`define CLFC_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define CLFC_ADDR_CTRL 8'h00
`define CLFC_ADDR_COMP 8'h04
`define CLFC_ADDR_MSG 8'h08
`define CLFC_ADDR_STAT 8'h0C
`define CLFC_ADDR_COUNT 8'h10
// ****************************************
// Fields
// ****************************************
`define CLFC_CTRL_EN 0
`define CLFC_CTRL_CLR 1
`define CLFC_STAT_VALID 0
`define CLFC_STAT_OVF 1
`define CLFC_CTRL_RST 32'h0000_0001
`define CLFC_EN_RST 1'b1
// ****************************************
// Cause codes
// ****************************************
`define CLFC_C_CRC 8'h01
`define CLFC_C_SHORT 8'h02
`define CLFC_C_LONG 8'h03
`define CLFC_C_LEN 8'h04
`define CLFC_C_TYPE 8'h05
`define CLFC_C_ADDR 8'h06
`define CLFC_C_SUPPLY 8'h09
`define CLFC_C_LIFE 8'h0A
`define CLFC_C_ALTSYNC 8'h0B
`define CLFC_C_EARLY 8'h10
`define CLFC_C_ERRBIT_E 8'h19
`define CLFC_C_LIFE_E 8'h1A
`define CLFC_C_HDR 8'h20
`define CLFC_C_MISS 8'h21
`define CLFC_C_RXTO 8'h22
`define CLFC_C_RXBUF 8'h23
`define CLFC_C_TXTO 8'h40
`define CLFC_C_TXTYPE 8'h41
`define CLFC_C_TXBUF1 8'h42
`define CLFC_C_TXBUF2 8'h43
`define CLFC_C_RTLATE 8'h60
`define CLFC_C_CHARTO 8'h61
`define CLFC_C_TRANS 8'h62
`define CLFC_ZERO8 8'h00
`endif

// file: verilog/clfc_top.sv
// Cyclic link fault classifier: fault detection to message value, register port
`include "clfc_regs.svh"
module clfc_top
  import clfc_pkg::*;
#(
  parameter int CWIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Receive telegram check results, valid with rx_done
  input wire logic rx_done,
  input wire logic rx_crc_bad,
  input wire logic rx_short,
  input wire logic rx_long,
  input wire logic rx_len_bad,
  input wire logic rx_type_bad,
  input wire logic rx_addr_bad,
  input wire logic rx_supply_fail,
  input wire logic rx_err_bit,
  input wire logic rx_life_missing,
  input wire logic rx_early,
  input wire logic rx_hdr_bad,
  input wire logic rx_buf_bad,
  // Link events, one-cycle pulses
  input wire logic ev_miss,
  input wire logic ev_rx_timeout,
  input wire logic ev_tx_timeout,
  input wire logic ev_trans_fail,
  input wire logic ev_tx_buf_bad1,
  input wire logic ev_tx_buf_bad2,
  input wire logic ev_rt_late,
  input wire logic ev_char_slow,
  input wire logic ev_alt_sync,
  input wire logic ev_prop_change,
  // Send request with type check
  input wire logic tx_req,
  input wire logic tx_type_bad,
  output logic tx_go,
  // Fault report
  output logic fault_pulse,
  output logic [31:0] fault_msg
);

  // ****************************************
  // Registers
  // ****************************************
  logic enable_reg; // Classifier enable
  logic [7:0] comp_reg; // Component number
  clfc_word_t msg_reg; // Last message value
  logic valid_reg; // Message held
  logic ovf_reg; // Message replaced before clear
  logic [CWIDTH-1:0] count_reg; // Fault count
  logic [31:0] rdata_reg; // Read data
  logic pulse_reg; // Report strobe

  // ****************************************
  // Cause selection
  // ****************************************
  logic hit; // A fault this cycle
  logic [7:0] cause; // Selected cause
  logic prop; // Property change has own format
  logic tx_block; // Send refused

  assign tx_block = tx_req && tx_type_bad;

  // Priority: receive telegram first, then send type block, then link events
  always_comb begin
    hit = 1'b1;
    prop = 1'b0;
    cause = `CLFC_ZERO8;
    if (rx_done && rx_hdr_bad) begin
      cause = `CLFC_C_HDR;
    end else if (rx_done && rx_buf_bad) begin
      cause = `CLFC_C_RXBUF;
    end else if (rx_done && rx_life_missing) begin
      cause = rx_early ? `CLFC_C_LIFE_E : `CLFC_C_LIFE;
    end else if (rx_done && rx_crc_bad) begin
      cause = rx_early ? (`CLFC_C_CRC | `CLFC_C_EARLY) : `CLFC_C_CRC;
    end else if (rx_done && rx_short) begin
      cause = rx_early ? (`CLFC_C_SHORT | `CLFC_C_EARLY) : `CLFC_C_SHORT;
    end else if (rx_done && rx_long) begin
      cause = rx_early ? (`CLFC_C_LONG | `CLFC_C_EARLY) : `CLFC_C_LONG;
    end else if (rx_done && rx_len_bad) begin
      cause = rx_early ? (`CLFC_C_LEN | `CLFC_C_EARLY) : `CLFC_C_LEN;
    end else if (rx_done && rx_type_bad) begin
      cause = rx_early ? (`CLFC_C_TYPE | `CLFC_C_EARLY) : `CLFC_C_TYPE;
    end else if (rx_done && rx_addr_bad) begin
      cause = rx_early ? (`CLFC_C_ADDR | `CLFC_C_EARLY) : `CLFC_C_ADDR;
    end else if (rx_done && rx_supply_fail) begin
      cause = `CLFC_C_SUPPLY;
    end else if (rx_done && rx_early && rx_err_bit) begin
      cause = `CLFC_C_ERRBIT_E;
    end else if (rx_done && rx_early) begin
      cause = `CLFC_C_EARLY;
    end else if (tx_block) begin
      cause = `CLFC_C_TXTYPE;
    end else if (ev_miss) begin
      cause = `CLFC_C_MISS;
    end else if (ev_rx_timeout) begin
      cause = `CLFC_C_RXTO;
    end else if (ev_tx_timeout) begin
      cause = `CLFC_C_TXTO;
    end else if (ev_trans_fail) begin
      cause = `CLFC_C_TRANS;
    end else if (ev_tx_buf_bad1) begin
      cause = `CLFC_C_TXBUF1;
    end else if (ev_tx_buf_bad2) begin
      cause = `CLFC_C_TXBUF2;
    end else if (ev_rt_late) begin
      cause = `CLFC_C_RTLATE;
    end else if (ev_char_slow) begin
      cause = `CLFC_C_CHARTO;
    end else if (ev_alt_sync) begin
      cause = `CLFC_C_ALTSYNC;
    end else if (ev_prop_change) begin
      prop = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // Send passes only when its type agrees
  assign tx_go = tx_req && !tx_type_bad && enable_reg;

  logic fire; // Report taken
  assign fire = hit && enable_reg;

  // ****************************************
  // Message capture
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      msg_reg <= 32'h0000_0000;
    end else if (fire) begin
      if (prop) begin
        msg_reg <= {24'h00_0000, comp_reg};
      end else begin
        msg_reg <= {16'h0000, comp_reg, cause};
      end
    end
  end

  // Report strobe one cycle after the fault
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= fire;
    end
  end

  // Valid and overflow flags; a new fault wins over a clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else if (fire) begin
      valid_reg <= 1'b1;
      ovf_reg <= ovf_reg | valid_reg;
    end else if (reg_wr && reg_addr == `CLFC_ADDR_CTRL && reg_wdata[`CLFC_CTRL_CLR]) begin
      valid_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end
  end

  // Fault counter, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (fire && !(&count_reg)) begin
      count_reg <= count_reg + 1'b1;
    end else if (!fire && reg_wr && reg_addr == `CLFC_ADDR_CTRL && reg_wdata[`CLFC_CTRL_CLR]) begin
      count_reg <= '0;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Single-bit enable comes up set, matching the control reset word
      enable_reg <= `CLFC_EN_RST;
      comp_reg <= `CLFC_ZERO8;
    end else if (reg_wr) begin
      case (reg_addr)
        `CLFC_ADDR_CTRL: begin
          enable_reg <= reg_wdata[`CLFC_CTRL_EN];
        end
        `CLFC_ADDR_COMP: begin
          comp_reg <= reg_wdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Register reads, data one cycle later
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CLFC_ADDR_CTRL: rdata_reg <= {31'h0000_0000, enable_reg};
        `CLFC_ADDR_COMP: rdata_reg <= {24'h00_0000, comp_reg};
        `CLFC_ADDR_MSG: rdata_reg <= msg_reg;
        `CLFC_ADDR_STAT: rdata_reg <= {30'h0000_0000, ovf_reg, valid_reg};
        `CLFC_ADDR_COUNT: rdata_reg <= 32'(count_reg);
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;
  assign fault_pulse = pulse_reg;
  assign fault_msg = msg_reg;

endmodule : clfc_top
